// ==== rtl/tcr_pkg.sv ====
// Purpose: constants and types of the touch controller config registers
// Assumes: 8-bit register port fed by the serial front end on core_clk_i
// Notes:   reset values are plain defaults
package tcr_pkg;
  // register offsets
  localparam logic [7:0] OFF_IRQ_SRC  = 8'h00;
  localparam logic [7:0] OFF_PIN_FN   = 8'h07;
  localparam logic [7:0] OFF_PWR_KEY  = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h09;
  localparam logic [7:0] OFF_LED_MAP1 = 8'h0c;
  localparam logic [7:0] OFF_LED_MAP2 = 8'h0d;
  localparam logic [7:0] OFF_PWM_DIV  = 8'h0e;
  localparam logic [7:0] OFF_SOFT_RST = 8'hff;
  // field positions and writable masks
  localparam int         FN_LSB       = 5;
  localparam int         PSTATE_BIT   = 4;
  localparam logic [7:0] PIN_FN_WMASK = 8'h70;
  localparam logic [7:0] MASK_WMASK   = 8'hfc;
  localparam int         EVT_RESET    = 7;
  localparam logic [7:0] EVT_USED     = 8'h7c;
  // soft reset key pair
  localparam logic [7:0] SRST_KEY1    = 8'hde;
  localparam logic [7:0] SRST_KEY2    = 8'h00;
  // reset values
  localparam logic [7:0] RST_PIN_FN   = 8'h00;
  localparam logic [7:0] RST_PWR_KEY  = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  localparam logic [7:0] RST_LED_MAP  = 8'h00;
  localparam logic [7:0] RST_PWM_DIV  = 8'h00;
  localparam logic [7:0] RST_IRQ_SRC  = 8'h80;
  // timing
  localparam int CLK_HZ  = 10_000_000;
  localparam int OSC_HZ  = 2_000_000;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam logic [2:0] OSC_LAST = 3'(OSC_DIV - 1);

  typedef enum logic [1:0] {
    FN_IRQ  = 2'h0,
    FN_BUZ  = 2'h1,
    FN_ANA2 = 2'h2,
    FN_PWR  = 2'h3
  } tcr_fn_e;

  typedef enum logic {
    SR_IDLE  = 1'h0,
    SR_ARMED = 1'h1
  } tcr_srst_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tcr_req_s;
endpackage : tcr_pkg

// ==== rtl/tcr_regs.sv ====
// Purpose: host configuration registers of the touch controller
// Assumes: reg_req_i comes from a serial slave on core_clk_i, one-cycle
//          strobes; events and touch levels are on core_clk_i
// Notes:   multipurpose pin input is asynchronous and synchronised here
`timescale 1ns/1ps
`default_nettype none
// Contract
// [RL1] two-bit field selects multipurpose pin role
// [RL2] irq role pulls low, released on source read
// [RL3] power bit follows pin or host write
// [RL4] pin high means power on, low off
// [RL5] host writes reserved bits as zero
// [RL6] power-key map channel touch pulses power-on
// [RL7] channel 7 enable makes it main button
// [RL8] mask bits enable reset/touch/release/near/far/comp
// [RL9] unmasked events reach pin only irq role
// [RL10] 0xde then 0x00 at 0xff resets device
// [RL11] engine one map assigns channel leds
// [RL12] engine two map assigns channel leds
// [RL13] channel may sit in both engines
// [RL14] pwm rate is 2MHz over divider n
// [RL15] buzzer role drives buzzer waveform out
// [RL16] analog role hands pin to second output
// [RL17] source flags all events, mask notwithstanding
// [RL18] wrong second key discards soft reset; here a second key of 0xde keeps the sequence armed
// [RL19] divider zero acts as largest divisor
module tcr_regs (
  // clock, reset, enable
  input  wire logic             core_clk_i,
  input  wire logic             rstn_i,
  input  wire logic             clk_en_i,
  // register port
  input  wire tcr_pkg::tcr_req_s reg_req_i,
  output logic [7:0]            reg_rdata_o,
  output logic                  reg_rvalid_o,
  // sensing side
  input  wire logic [7:0]       touch_i,
  input  wire logic [7:0]       evt_i,
  input  wire logic             ch7_pwr_en_i,
  input  wire logic             buzzer_wave_i,
  // multipurpose pin
  input  wire logic             mpin_i,
  output logic                  mpin_o,
  output logic                  mpin_oe_o,
  output logic                  ana2_sel_o,
  // system side
  output logic                  power_on_pulse_o,
  output logic                  main_button_o,
  output logic                  sys_power_state_o,
  output logic                  soft_reset_o,
  output logic [7:0]            led_eng1_map_o,
  output logic [7:0]            led_eng2_map_o,
  output logic                  led_pwm_tick_o
);
  function automatic logic hit(input tcr_pkg::tcr_req_s r,
                               input logic [7:0] off);
    hit = r.addr == off;
  endfunction : hit

  logic [7:0]         fn_q, fn_d, key_q, key_d, msk_q, msk_d;
  logic [7:0]         m1_q, m1_d, m2_q, m2_d, div_q, div_d;
  logic [7:0]         src_q, src_d, tprev_q, tprev_d;
  logic [7:0]         rdat_q, rdat_d, pcnt_q, pcnt_d, plast;
  logic [2:0]         ocnt_q, ocnt_d;
  logic               otick_q, otick_d;
  tcr_pkg::tcr_srst_e sr_q, sr_d;
  logic               s1_q, s2_q;
  logic               rv_q, rv_d, pon_q, pon_d, mb_q, mb_d;
  logic               pst_q, pst_d, srst_q, srst_d, tick_q, tick_d;
  logic               oe_q, oe_d, out_q, out_d, ana_q, ana_d;
  logic               wr_ff, src_rd, fire;
  logic [7:0]         rise;
  tcr_pkg::tcr_fn_e   role;

  assign role = tcr_pkg::tcr_fn_e'(fn_q[tcr_pkg::FN_LSB +: 2]);
  assign rise = touch_i & ~tprev_q;
  assign wr_ff = reg_req_i.wr && hit(reg_req_i, tcr_pkg::OFF_SOFT_RST);
  assign src_rd = reg_req_i.rd && hit(reg_req_i, tcr_pkg::OFF_IRQ_SRC);
  assign fire = wr_ff && sr_q == tcr_pkg::SR_ARMED
                && reg_req_i.wdata == tcr_pkg::SRST_KEY2;
  // divider zero stands for 256 steps
  assign plast = div_q - 8'h01; // see [RL19]

  always_comb begin
    fn_d = fn_q;
    key_d = key_q;
    msk_d = msk_q;
    m1_d = m1_q;
    m2_d = m2_q;
    div_d = div_q;
    sr_d = sr_q;
    srst_d = 1'b0;
    if (reg_req_i.wr) begin
      // reserved bits are held at zero whatever the host sends
      if (hit(reg_req_i, tcr_pkg::OFF_PIN_FN)) begin
        fn_d = reg_req_i.wdata & tcr_pkg::PIN_FN_WMASK; // see [RL5]
      end
      if (hit(reg_req_i, tcr_pkg::OFF_PWR_KEY)) begin
        key_d = reg_req_i.wdata;
      end
      if (hit(reg_req_i, tcr_pkg::OFF_IRQ_MASK)) begin
        msk_d = reg_req_i.wdata & tcr_pkg::MASK_WMASK; // see [RL8]
      end
      if (hit(reg_req_i, tcr_pkg::OFF_LED_MAP1)) begin
        m1_d = reg_req_i.wdata; // see [RL11]
      end
      if (hit(reg_req_i, tcr_pkg::OFF_LED_MAP2)) begin
        m2_d = reg_req_i.wdata; // see [RL12]
      end
      if (hit(reg_req_i, tcr_pkg::OFF_PWM_DIV)) begin
        div_d = reg_req_i.wdata;
      end
    end
    if (wr_ff) begin
      case (sr_q)
        tcr_pkg::SR_IDLE: begin
          if (reg_req_i.wdata == tcr_pkg::SRST_KEY1) begin
            sr_d = tcr_pkg::SR_ARMED;
          end
        end
        tcr_pkg::SR_ARMED: begin
          // a second byte other than 0x00 or 0xde drops the sequence; 0xde keeps it armed
          sr_d = (reg_req_i.wdata == tcr_pkg::SRST_KEY1) ?
                 tcr_pkg::SR_ARMED : tcr_pkg::SR_IDLE; // see [RL18]
        end
        default: sr_d = tcr_pkg::SR_IDLE;
      endcase
    end
    if (fire) begin
      // config returns to defaults; the loader then refills it
      srst_d = 1'b1; // see [RL10]
      sr_d = tcr_pkg::SR_IDLE;
      fn_d = tcr_pkg::RST_PIN_FN;
      key_d = tcr_pkg::RST_PWR_KEY;
      msk_d = tcr_pkg::RST_IRQ_MASK;
      m1_d = tcr_pkg::RST_LED_MAP;
      m2_d = tcr_pkg::RST_LED_MAP;
      div_d = tcr_pkg::RST_PWM_DIV;
    end
  end

  always_comb begin
    tprev_d = touch_i;
    // set wins over the clear by read, mask not applied here
    src_d = src_rd ? 8'h00 : src_q;
    src_d = src_d | (evt_i & tcr_pkg::EVT_USED); // see [RL17]
    if (fire) begin
      src_d[tcr_pkg::EVT_RESET] = 1'b1;
    end
    pon_d = |(rise & key_q); // see [RL6]
    mb_d = ch7_pwr_en_i & touch_i[7]; // see [RL7]
    // pin level high is power on in the input role
    pst_d = (role == tcr_pkg::FN_PWR) ? s2_q
            : fn_q[tcr_pkg::PSTATE_BIT]; // see [RL3] [RL4]
    oe_d = 1'b0;
    out_d = 1'b0;
    ana_d = 1'b0;
    case (role) // see [RL1]
      tcr_pkg::FN_IRQ: oe_d = |(src_q & msk_q); // see [RL2] [RL9]
      tcr_pkg::FN_BUZ: begin
        oe_d = 1'b1;
        out_d = buzzer_wave_i; // see [RL15]
      end
      tcr_pkg::FN_ANA2: ana_d = 1'b1; // see [RL16]
      tcr_pkg::FN_PWR: oe_d = 1'b0;
      default: oe_d = 1'b0;
    endcase
    rv_d = reg_req_i.rd;
    rdat_d = rdat_q;
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        tcr_pkg::OFF_IRQ_SRC:  rdat_d = src_q;
        tcr_pkg::OFF_PIN_FN: begin
          rdat_d = fn_q;
          rdat_d[tcr_pkg::PSTATE_BIT] = pst_q;
        end
        tcr_pkg::OFF_PWR_KEY:  rdat_d = key_q;
        tcr_pkg::OFF_IRQ_MASK: rdat_d = msk_q;
        tcr_pkg::OFF_LED_MAP1: rdat_d = m1_q;
        tcr_pkg::OFF_LED_MAP2: rdat_d = m2_q;
        tcr_pkg::OFF_PWM_DIV:  rdat_d = div_q;
        default:               rdat_d = 8'h00;
      endcase
    end
    // 2MHz tick from the core clock, then divide by n
    otick_d = ocnt_q == tcr_pkg::OSC_LAST;
    ocnt_d = otick_d ? 3'h0 : ocnt_q + 3'h1;
    pcnt_d = pcnt_q;
    tick_d = 1'b0;
    if (otick_q) begin
      tick_d = pcnt_q == plast; // see [RL14]
      pcnt_d = tick_d ? 8'h00 : pcnt_q + 8'h01;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fn_q <= tcr_pkg::RST_PIN_FN;
      key_q <= tcr_pkg::RST_PWR_KEY;
      msk_q <= tcr_pkg::RST_IRQ_MASK;
      m1_q <= tcr_pkg::RST_LED_MAP;
      m2_q <= tcr_pkg::RST_LED_MAP;
      div_q <= tcr_pkg::RST_PWM_DIV;
      sr_q <= tcr_pkg::SR_IDLE;
      srst_q <= 1'b0;
    end else if (clk_en_i) begin
      fn_q <= fn_d;
      key_q <= key_d;
      msk_q <= msk_d;
      m1_q <= m1_d;
      m2_q <= m2_d;
      div_q <= div_d;
      sr_q <= sr_d;
      srst_q <= srst_d;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      tprev_q <= 8'h00;
      src_q <= tcr_pkg::RST_IRQ_SRC;
      pon_q <= 1'b0;
      mb_q <= 1'b0;
      pst_q <= 1'b0;
      oe_q <= 1'b0;
      out_q <= 1'b0;
      ana_q <= 1'b0;
      rv_q <= 1'b0;
      rdat_q <= 8'h00;
      ocnt_q <= 3'h0;
      otick_q <= 1'b0;
      pcnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else if (clk_en_i) begin
      s1_q <= mpin_i;
      s2_q <= s1_q;
      tprev_q <= tprev_d;
      src_q <= src_d;
      pon_q <= pon_d;
      mb_q <= mb_d;
      pst_q <= pst_d;
      oe_q <= oe_d;
      out_q <= out_d;
      ana_q <= ana_d;
      rv_q <= rv_d;
      rdat_q <= rdat_d;
      ocnt_q <= ocnt_d;
      otick_q <= otick_d;
      pcnt_q <= pcnt_d;
      tick_q <= tick_d;
    end
  end

  assign reg_rdata_o = rdat_q;
  assign reg_rvalid_o = rv_q;
  assign mpin_o = out_q;
  assign mpin_oe_o = oe_q;
  assign ana2_sel_o = ana_q;
  assign power_on_pulse_o = pon_q;
  assign main_button_o = mb_q;
  assign sys_power_state_o = pst_q;
  assign soft_reset_o = srst_q;
  // both maps are independent, so a channel may sit in both
  assign led_eng1_map_o = m1_q; // see [RL13]
  assign led_eng2_map_o = m2_q;
  assign led_pwm_tick_o = tick_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_irq_pull;
    clk_en_i && role == tcr_pkg::FN_IRQ && |(src_q & msk_q)
      |=> mpin_oe_o && !mpin_o;
  endproperty
  a_irq_pull: assert property (p_irq_pull) // see [RL2]
    else $error("irq pin not pulled low");
  property p_irq_release;
    clk_en_i && src_rd && !fire && evt_i == 8'h00
      ##1 clk_en_i && evt_i == 8'h00 && role == tcr_pkg::FN_IRQ
      |=> !mpin_oe_o;
  endproperty
  a_irq_release: assert property (p_irq_release) // see [RL2]
    else $error("irq pin not released after read");
  property p_no_drive;
    clk_en_i && (role == tcr_pkg::FN_ANA2 || role == tcr_pkg::FN_PWR)
      |=> !mpin_oe_o;
  endproperty
  a_no_drive: assert property (p_no_drive) // see [RL9]
    else $error("pin driven outside irq or buzzer role");
  property p_pstate;
    clk_en_i && role == tcr_pkg::FN_PWR |=> pst_q == $past(s2_q);
  endproperty
  a_pstate: assert property (p_pstate) // see [RL4]
    else $error("power state does not follow pin");
  property p_power_on_pulse_out;
    clk_en_i && |(rise & key_q) |=> power_on_pulse_o;
  endproperty
  a_power_on_pulse_out: assert property (p_power_on_pulse_out) // see [RL6]
    else $error("power key touch gave no pulse");
  property p_srst;
    clk_en_i && fire |=> soft_reset_o && src_q[tcr_pkg::EVT_RESET]
      && fn_q == tcr_pkg::RST_PIN_FN;
  endproperty
  a_srst: assert property (p_srst) // see [RL10]
    else $error("soft reset sequence not honoured");
  property p_srst_drop;
    clk_en_i && wr_ff && sr_q == tcr_pkg::SR_ARMED
      && reg_req_i.wdata != tcr_pkg::SRST_KEY2
      |=> !soft_reset_o;
  endproperty
  a_srst_drop: assert property (p_srst_drop) // see [RL18]
    else $error("bad second key caused reset");
  property p_src_set;
    clk_en_i && evt_i[6] |=> src_q[6];
  endproperty
  a_src_set: assert property (p_src_set) // see [RL17]
    else $error("touch event lost in source");
  property p_map;
    clk_en_i && !fire && reg_req_i.wr
      && hit(reg_req_i, tcr_pkg::OFF_LED_MAP1)
      |=> led_eng1_map_o == $past(reg_req_i.wdata);
  endproperty
  a_map: assert property (p_map) // see [RL11]
    else $error("engine one map not written");
  property p_pwm;
    clk_en_i && otick_q && pcnt_q == plast |=> led_pwm_tick_o;
  endproperty
  a_pwm: assert property (p_pwm) // see [RL14]
    else $error("pwm tick missing at divider end");
  property p_main;
    clk_en_i |=> main_button_o == $past(ch7_pwr_en_i & touch_i[7]);
  endproperty
  a_main: assert property (p_main) // see [RL7]
    else $error("main button mismatch");

  c_srst: cover property (clk_en_i && fire);
  c_irq: cover property (mpin_oe_o && role == tcr_pkg::FN_IRQ);
  c_power_on_pulse_out: cover property (power_on_pulse_o);
  c_tick: cover property (led_pwm_tick_o);
endmodule : tcr_regs
`default_nettype wire

// ==== tb/tcr_pin_model.sv ====
// Purpose: system side of the multipurpose pin
// Assumes: pull-up on the wire; manager drives only in the input role
// Notes:   a released open-drain pin reads high through the pull-up
`timescale 1ns/1ps
`default_nettype none
module tcr_pin_model (
  // device side
  input  wire logic pin_val_i,
  input  wire logic pin_oe_i,
  // power manager side
  input  wire logic pm_drv_i,
  input  wire logic pm_lvl_i,
  // resolved wire
  output logic      pin_lvl_o
);
  // device wins, then manager, else pull-up; never a stale value
  assign pin_lvl_o = pin_oe_i ? pin_val_i :
                     (pm_drv_i ? pm_lvl_i : 1'b1);
endmodule : tcr_pin_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench for the touch controller config registers
// Assumes: strobe register port, inputs driven on the falling edge
// Notes:   pulse outputs are counted so their exact cycle is not assumed
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  num_errors++; $display("Error %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic              core_clk_i = 1'b0;
  logic              rstn_i     = 1'b0;
  tcr_pkg::tcr_req_s req        = '0;
  logic [7:0]        touch      = 8'h00;
  logic [7:0]        evt        = 8'h00;
  logic              ch7_en     = 1'b0;
  logic              wave       = 1'b0;
  logic              clk_en     = 1'b1;
  logic              pm_drv     = 1'b0;
  logic              pm_lvl     = 1'b0;
  logic [7:0]        rdata, map1, map2, rd_q;
  logic              rvalid, pin, pin_o, pin_oe, ana2, pon, mbtn;
  logic              pst, srst, tick;
  int                num_errors = 0;
  int                compares   = 0;
  int                pon_cnt    = 0;
  int                srst_cnt   = 0;
  int                n;

  always #50 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    pon_cnt  += pon;
    srst_cnt += srst;
  end

  tcr_regs DUT (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .clk_en_i(clk_en),
    .reg_req_i(req), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .touch_i(touch), .evt_i(evt), .ch7_pwr_en_i(ch7_en),
    .buzzer_wave_i(wave), .mpin_i(pin), .mpin_o(pin_o),
    .mpin_oe_o(pin_oe), .ana2_sel_o(ana2), .power_on_pulse_o(pon),
    .main_button_o(mbtn), .sys_power_state_o(pst), .soft_reset_o(srst),
    .led_eng1_map_o(map1), .led_eng2_map_o(map2), .led_pwm_tick_o(tick));

  tcr_pin_model PM (.pin_val_i(pin_o), .pin_oe_i(pin_oe),
    .pm_drv_i(pm_drv), .pm_lvl_i(pm_lvl), .pin_lvl_o(pin));

  task cyc(input int k);
    repeat (k) @(negedge core_clk_i);
  endtask : cyc

  // an idle cycle after each strobe keeps one assignment per time step
  task wr(input logic [7:0] a, input logic [7:0] d);
    req = '{1'b1, 1'b0, a, d};
    cyc(1);
    req = '0;
    cyc(1);
  endtask : wr

  // rvalid stands one cycle only, so it is looked at before the strobe drops
  task rd(input logic [7:0] a);
    req = '{1'b0, 1'b1, a, 8'h00};
    cyc(1);
    `CHK("rvalid", 1'b1, rvalid)
    rd_q = rdata;
    req = '0;
    cyc(1);
  endtask : rd

  task chk_rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK(nm, e, rd_q)
  endtask : chk_rd

  task t_reset;
    logic [7:0] offs [7];
    offs = '{8'h07, 8'h08, 8'h09, 8'h0c, 8'h0d, 8'h0e, 8'hff};
    foreach (offs[i]) chk_rd("reset_val", offs[i], 8'h00);
    `CHK("oe_reset", 1'b0, pin_oe)
  endtask : t_reset

  task t_regs;
    wr(8'h07, 8'h9f);
    chk_rd("pin_fn", 8'h07, 8'h10);
    `CHK("pstate_wr", 1'b1, pst)
    wr(8'h09, 8'hff);
    chk_rd("mask", 8'h09, 8'hfc);
    // the reset event bit left from power-up now reaches the pin
    `CHK("oe_reset_evt", 1'b1, pin_oe)
    wr(8'h0c, 8'ha5);
    wr(8'h0d, 8'h3c);
    `CHK("map1", 8'ha5, map1)
    `CHK("map2", 8'h3c, map2)
    chk_rd("map2_rd", 8'h0d, 8'h3c);
    // a write while the enable is low must not land
    clk_en = 1'b0;
    wr(8'h0c, 8'h00);
    clk_en = 1'b1;
    `CHK("map1_frozen", 8'ha5, map1)
  endtask : t_regs

  task t_irq;
    wr(8'h09, 8'h40);
    wr(8'h07, 8'h00);
    chk_rd("src_rst", 8'h00, 8'h80);
    cyc(2);
    `CHK("oe_clr", 1'b0, pin_oe)
    evt = 8'h20;
    cyc(1);
    evt = 8'h00;
    cyc(3);
    `CHK("oe_masked", 1'b0, pin_oe)
    chk_rd("src_masked", 8'h00, 8'h20);
    evt = 8'h40;
    cyc(1);
    evt = 8'h00;
    cyc(2);
    `CHK("oe_irq", 1'b1, pin_oe)
    `CHK("pin_low", 1'b0, pin)
    chk_rd("src_touch", 8'h00, 8'h40);
    cyc(1);
    `CHK("oe_release", 1'b0, pin_oe)
    wr(8'h07, 8'h40);
    evt = 8'h40;
    cyc(1);
    evt = 8'h00;
    cyc(3);
    `CHK("oe_role", 1'b0, pin_oe)
    rd(8'h00);
  endtask : t_irq

  task t_roles;
    wr(8'h07, 8'h20);
    wave = 1'b1;
    cyc(2);
    `CHK("buz_oe", 1'b1, pin_oe)
    `CHK("buz_hi", 1'b1, pin_o)
    wave = 1'b0;
    cyc(2);
    `CHK("buz_lo", 1'b0, pin_o)
    wr(8'h07, 8'h40);
    cyc(1);
    `CHK("ana2", 1'b1, ana2)
    `CHK("ana2_oe", 1'b0, pin_oe)
    wr(8'h07, 8'h60);
    pm_drv = 1'b1;
    pm_lvl = 1'b1;
    cyc(4);
    `CHK("pst_on", 1'b1, pst)
    chk_rd("pst_rd", 8'h07, 8'h70);
    pm_lvl = 1'b0;
    cyc(4);
    `CHK("pst_off", 1'b0, pst)
    `CHK("ana2_off", 1'b0, ana2)
    pm_drv = 1'b0;
    wr(8'h07, 8'h00);
  endtask : t_roles

  task t_pwr_key;
    wr(8'h08, 8'h81);
    n = pon_cnt;
    touch = 8'h80;
    cyc(4);
    touch = 8'h82;
    cyc(4);
    `CHK("pon_ch7", 1, pon_cnt - n)
    touch = 8'h83;
    cyc(4);
    `CHK("pon_ch0", 2, pon_cnt - n)
    ch7_en = 1'b1;
    cyc(2);
    `CHK("main_on", 1'b1, mbtn)
    ch7_en = 1'b0;
    cyc(2);
    `CHK("main_off", 1'b0, mbtn)
    touch = 8'h00;
  endtask : t_pwr_key

  task t_soft;
    n = srst_cnt;
    wr(8'hff, 8'hde);
    wr(8'h08, 8'h11);
    wr(8'hff, 8'h12);
    cyc(3);
    `CHK("srst_bad", 0, srst_cnt - n)
    wr(8'hff, 8'hde);
    wr(8'hff, 8'h00);
    cyc(2);
    `CHK("srst_fire", 1, srst_cnt - n)
    chk_rd("key_dflt", 8'h08, 8'h00);
    chk_rd("src_srst", 8'h00, 8'h80);
  endtask : t_soft

  task pwm(input logic [7:0] d, input int e);
    int k;
    int t0;
    int t1;
    k  = 0;
    t0 = 0;
    t1 = 0;
    wr(8'h0e, d);
    while (k < 3 && t1 < 4000) begin
      cyc(1);
      t1++;
      if (tick === 1'b1) begin
        k++;
        if (k == 2) t0 = t1;
      end
    end
    `CHK("pwm_period", e, t1 - t0)
  endtask : pwm

  task finish_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  initial begin
    cyc(5);
    rstn_i = 1'b1;
    cyc(1);
    t_reset();
    t_regs();
    t_irq();
    t_roles();
    t_pwr_key();
    t_soft();
    pwm(8'h02, 10);
    pwm(8'h01, 5);
    pwm(8'h00, 1280);
    finish_test();
  end

  // whole run needs well under 10000 cycles
  initial begin
    #2_000_000;
    num_errors++;
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
